/* hw/exmon_pkg.sv */
package exmon_pkg;
    // requester of an access into the memory system
    typedef enum logic [1:0] {
        EXMON_SRC_CORE,
        EXMON_SRC_TCM_SLAVE,
        EXMON_SRC_DEBUG,
        EXMON_SRC_SELFTEST
    } exmon_src_t;

    // port that serves the target address
    typedef enum logic [2:0] {
        EXMON_TGT_TCM,
        EXMON_TGT_MAIN,
        EXMON_TGT_PERIPH,
        EXMON_TGT_PRIV
    } exmon_tgt_t;

    // memory type of the target region
    typedef enum logic [0:0] {
        EXMON_MEM_NORMAL,
        EXMON_MEM_DEVICE
    } exmon_mem_t;

    // state of the tracker for the external exclusive attempt
    typedef enum logic [1:0] {
        EXMON_ST_IDLE,
        EXMON_ST_WAIT
    } exmon_st_t;

    localparam logic EXMON_RESET_OPEN = 1'b0;
    localparam logic EXMON_HAS_GLOBAL_DEFAULT = 1'b1;
    localparam logic EXMON_HAS_PROT_DEFAULT = 1'b1;
endpackage

/* hw/exmon_attr.sv */
`timescale 1ns/1ns
// decides whether an access is shareable and whether it goes out exclusive
module exmon_attr
    import exmon_pkg::*;
(
    input wire logic has_prot,
    input wire exmon_tgt_t tgt,
    input wire exmon_mem_t mem,
    input wire logic region_shareable,
    input wire logic region_cacheable,
    output logic shareable,
    output logic ext_excl,
    output logic cacheable
);
    // without a protection unit normal memory is non-shareable; device stays shareable
    always_comb begin
        shareable = (mem == EXMON_MEM_DEVICE) ||
                    (has_prot && region_shareable);
        // only main and peripheral ports carry exclusive transfers
        ext_excl = shareable && ((tgt == EXMON_TGT_MAIN) ||
                   (tgt == EXMON_TGT_PERIPH));
        // shareable normal exclusive bypasses the cache
        cacheable = region_cacheable && !shareable &&
                    (mem == EXMON_MEM_NORMAL);
    end
endmodule

/* hw/exmon_resp.sv */
`timescale 1ns/1ns
// tracks one outstanding external exclusive and passes its okay status straight through
module exmon_resp
    import exmon_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic issue,
    input wire logic resp_valid,
    input wire logic resp_exokay,
    output logic busy,
    output logic done,
    output logic exokay
);
    exmon_st_t st_q;

    // wait for the single answer; a plain okay is no error
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= EXMON_ST_IDLE;
        end else begin
            unique case (st_q)
                EXMON_ST_IDLE: if (issue) st_q <= EXMON_ST_WAIT;
                EXMON_ST_WAIT: if (resp_valid) st_q <= EXMON_ST_IDLE;
                default: st_q <= EXMON_ST_IDLE;
            endcase
        end
    end

    assign busy = (st_q == EXMON_ST_WAIT);
    assign done = busy && resp_valid;
    assign exokay = resp_exokay;
endmodule

/* hw/exmon_top.sv */
`timescale 1ns/1ns
module exmon_top
    import exmon_pkg::*;
#(
    parameter logic HAS_GLOBAL = EXMON_HAS_GLOBAL_DEFAULT,
    parameter logic HAS_PROT = EXMON_HAS_PROT_DEFAULT
)(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic req_valid,
    input wire exmon_src_t req_src,
    input wire exmon_tgt_t req_tgt,
    input wire exmon_mem_t req_mem,
    input wire logic req_shareable,
    input wire logic req_cacheable,
    input wire logic exclusive_load_op,
    input wire logic exclusive_store_op,
    input wire logic exc_entry,
    input wire logic exc_return,
    input wire logic bus_resp_valid,
    input wire logic bus_resp_exokay,
    output logic bus_excl,
    output logic bus_cacheable,
    output logic store_done,
    output logic store_fail,
    output logic monitor_set
);
    logic mon_q;
    logic shareable;
    logic ext_excl;
    logic cacheable;
    logic core_req;
    logic load_sets;
    logic store_hit;
    logic resp_busy;
    logic resp_done;
    logic resp_exokay;
    logic issue_st;
    logic pend_mon_q;
    logic local_done;
    logic fail_d;
    logic ext_fail;
    logic out_d;
    logic park_q;
    logic park_fail_q;

    exmon_attr u_attr (
        .has_prot(HAS_PROT),
        .tgt(req_tgt),
        .mem(req_mem),
        .region_shareable(req_shareable),
        .region_cacheable(req_cacheable),
        .shareable(shareable),
        .ext_excl(ext_excl),
        .cacheable(cacheable)
    );

    // only core requests count; slave, debug, self-test ignored
    assign core_req = req_valid && (req_src == EXMON_SRC_CORE);

    // qualifying loads; private region and unsupported shareable skip
    assign load_sets = core_req && exclusive_load_op &&
        (req_tgt != EXMON_TGT_PRIV) &&
        (!shareable || HAS_GLOBAL || req_tgt == EXMON_TGT_TCM);

    assign store_hit = core_req && exclusive_store_op;
    assign issue_st = store_hit && ext_excl && !resp_busy;

    // single untagged bit; clears beat sets in the same cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mon_q <= EXMON_RESET_OPEN;
        end else if (store_hit || exc_entry || exc_return) begin
            mon_q <= 1'b0;
        end else if (load_sets) begin
            mon_q <= 1'b1;
        end
    end

    // keep monitor value seen at issue until the answer returns
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pend_mon_q <= 1'b0;
        end else if (issue_st) begin
            pend_mon_q <= mon_q;
        end
    end

    exmon_resp u_resp (
        .core_clk(core_clk),
        .resetn(resetn),
        .issue(issue_st),
        .resp_valid(bus_resp_valid),
        .resp_exokay(bus_resp_exokay),
        .busy(resp_busy),
        .done(resp_done),
        .exokay(resp_exokay)
    );

    // local-only stores resolve at once against the monitor
    assign local_done = store_hit && !ext_excl;
    // a plain okay is no fault, it only fails the store
    assign ext_fail = !(pend_mon_q && resp_exokay);

    // a local store resolving in the answer's cycle pushes the external
    // outcome back; one slot suffices because the next external store
    // is a cycle without a local store and so drains the slot first
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            park_q <= 1'b0;
            park_fail_q <= 1'b0;
        end else if (resp_done && local_done) begin
            park_q <= 1'b1;
            park_fail_q <= ext_fail;
        end else if (!local_done) begin
            park_q <= 1'b0;
        end
    end

    // local first, then a parked answer, then a fresh answer
    assign out_d = local_done || park_q || resp_done;
    assign fail_d = local_done ? !mon_q :
                    park_q ? park_fail_q : ext_fail;

    // outcome registered one cycle after resolution
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            store_done <= 1'b0;
            store_fail <= 1'b0;
        end else begin
            store_done <= out_d;
            store_fail <= out_d && fail_d;
        end
    end

    // exclusive marking on the bus; cache bypass for shareable
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bus_excl <= 1'b0;
            bus_cacheable <= 1'b0;
        end else begin
            // a store refused while one is pending goes out unmarked
            bus_excl <= (core_req && ext_excl && exclusive_load_op) ||
                issue_st;
            bus_cacheable <= core_req && cacheable;
        end
    end

    assign monitor_set = mon_q;

    // every exclusive store from the core drops the reservation
    store_clears_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        store_hit |=> !mon_q)
        else $error("store left monitor set");

    // exception entry and return both drop it
    exc_clears_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (exc_entry || exc_return) |=> !mon_q)
        else $error("exception left monitor set");

    // private region loads neither set nor clear
    priv_load_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (core_req && exclusive_load_op && req_tgt == EXMON_TGT_PRIV &&
         !exc_entry && !exc_return && !exclusive_store_op)
        |=> mon_q == $past(mon_q))
        else $error("private load changed monitor");

    // slave, debug and self-test traffic leaves it alone
    other_src_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (!core_req && !exc_entry && !exc_return) |=> $stable(mon_q))
        else $error("non-core access changed monitor");

    // a qualifying load with no clear in the cycle sets it
    load_sets_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (load_sets && !exclusive_store_op && !exc_entry && !exc_return)
        |=> mon_q)
        else $error("qualifying load did not set");

    // the only way up is a qualifying core load
    rise_cause_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        $rose(mon_q) |-> $past(load_sets))
        else $error("monitor set without a qualifying load");

    // the only way down is a store or an exception
    fall_cause_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        $fell(mon_q) |-> $past(store_hit) || $past(exc_entry) ||
            $past(exc_return))
        else $error("monitor dropped without a cause");

    // shareable loads outside the TCM need a global monitor to count
    no_global_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (core_req && exclusive_load_op && shareable && !HAS_GLOBAL &&
         req_tgt != EXMON_TGT_TCM && !exclusive_store_op &&
         !exc_entry && !exc_return) |=> $stable(mon_q))
        else $error("shareable load set monitor without global");

    // locally resolved exclusives never reach the bus
    nonshare_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (core_req && !ext_excl) |=> !bus_excl)
        else $error("local exclusive went to bus");

    // foreign requesters never mark a transfer exclusive
    src_mark_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !core_req |=> !bus_excl)
        else $error("non-core access marked exclusive");

    // ordinary accesses go out plain
    plain_mark_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (core_req && !exclusive_load_op && !exclusive_store_op)
        |=> !bus_excl)
        else $error("ordinary access marked exclusive");

    // shareable or device exclusive loads to main or peripheral go out marked
    ext_load_mark_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (core_req && exclusive_load_op && ext_excl) |=> bus_excl)
        else $error("external exclusive load not marked");

    // no protection unit: normal memory stays non-shareable
    no_prot_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (!HAS_PROT && core_req && req_mem == EXMON_MEM_NORMAL)
        |=> !bus_excl)
        else $error("normal memory went out exclusive");

    // shareable exclusives bypass the cache
    share_nocache_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (core_req && shareable) |=> !bus_cacheable)
        else $error("shareable access cacheable");

    // a local store without reservation reports failure
    local_fail_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (local_done && !mon_q) |=> store_done && store_fail)
        else $error("store without reservation passed");

    // a local store with reservation reports success
    local_pass_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (local_done && mon_q) |=> store_done && !store_fail)
        else $error("store with reservation failed");

    // a plain okay answer fails the store, no fault raised
    ext_fail_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (resp_done && !resp_exokay && !local_done && !park_q)
        |=> store_fail)
        else $error("plain okay let store pass");

    // an exclusive okay with reservation passes the store
    ext_pass_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (resp_done && resp_exokay && pend_mon_q && !local_done && !park_q)
        |=> store_done && !store_fail)
        else $error("exclusive okay store failed");

    // a reservation lost before issue fails the store despite okay
    nomon_fail_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (resp_done && !pend_mon_q && !local_done && !park_q)
        |=> store_fail)
        else $error("store passed without reservation");

    // a parked answer is reported once the local store is out
    park_out_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (park_q && !local_done) |=> store_done)
        else $error("parked outcome not reported");

    // failure is only ever shown with its done strobe
    fail_done_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        store_fail |-> store_done)
        else $error("fail without done");

    // an issued store holds the single outstanding slot
    one_out_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        issue_st |=> resp_busy)
        else $error("issued store not tracked");

    // load then a passing local store two cycles later
    load_cov_c: cover property (@(posedge core_clk) disable iff (!resetn)
        load_sets ##2 (local_done && !fail_d));
    // external store answered with exclusive okay
    ext_cov_c: cover property (@(posedge core_clk) disable iff (!resetn)
        issue_st ##[1:20] (resp_done && resp_exokay));
    // exception while a reservation stands
    exc_cov_c: cover property (@(posedge core_clk) disable iff (!resetn)
        mon_q && exc_entry);
    // external outcome parked behind a local store
    park_cov_c: cover property (@(posedge core_clk) disable iff (!resetn)
        park_q);
    // exclusive load into the private region
    priv_cov_c: cover property (@(posedge core_clk) disable iff (!resetn)
        core_req && exclusive_load_op && req_tgt == EXMON_TGT_PRIV);
endmodule

/* bench/exmon_far.sv */
`timescale 1ns/1ns
// interconnect stand-in answering external exclusive stores
module exmon_far (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic st_taken,
    input wire logic bus_excl,
    input wire logic has_global,
    output logic resp_valid,
    output logic resp_exokay
);
    logic st_q;
    logic [2:0] cnt_q;
    // slow answer keeps the store pending for a few cycles
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= 1'b0;
            cnt_q <= 3'h0;
            resp_valid <= 1'b0;
            resp_exokay <= 1'b0;
        end else begin
            st_q <= st_taken;
            resp_valid <= cnt_q == 3'h1;
            // okay only with a global monitor; toggles in every cycle without an answer
            resp_exokay <= (cnt_q == 3'h1) ? has_global : !resp_exokay;
            if (st_q && bus_excl)
                cnt_q <= 3'h3;
            else if (cnt_q != 3'h0)
                cnt_q <= cnt_q - 3'h1;
        end
    end
endmodule

/* bench/exmon_top_test.sv */
`timescale 1ns/1ns
module exmon_top_test;
    import exmon_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic req_valid = 1'b0;
    exmon_src_t req_src = EXMON_SRC_CORE;
    exmon_tgt_t req_tgt = EXMON_TGT_TCM;
    exmon_mem_t req_mem = EXMON_MEM_NORMAL;
    logic req_shareable = 1'b0;
    logic req_cacheable = 1'b0;
    logic exclusive_load_op = 1'b0;
    logic exclusive_store_op = 1'b0;
    logic exc_entry = 1'b0;
    logic exc_return = 1'b0;
    logic give_okay = 1'b1;
    logic rv, rx, bus_excl, bus_cacheable, store_done, store_fail;
    logic monitor_set, excl2, excl3, mon2, st_taken;
    int fails = 0;
    int tests_run = 0;
    // the far side only cares about stores the core itself made
    assign st_taken = req_valid && exclusive_store_op
        && req_src == EXMON_SRC_CORE;
    always #10 core_clk = !core_clk;
    exmon_far exmon_far_i (.core_clk(core_clk), .resetn(resetn),
        .st_taken(st_taken), .bus_excl(bus_excl), .has_global(give_okay),
        .resp_valid(rv), .resp_exokay(rx));
    exmon_top exmon_top_i (.core_clk(core_clk), .resetn(resetn),
        .req_valid(req_valid), .req_src(req_src), .req_tgt(req_tgt),
        .req_mem(req_mem), .req_shareable(req_shareable),
        .req_cacheable(req_cacheable), .exclusive_load_op(exclusive_load_op),
        .exclusive_store_op(exclusive_store_op), .exc_entry(exc_entry),
        .exc_return(exc_return), .bus_resp_valid(rv), .bus_resp_exokay(rx),
        .bus_excl(bus_excl), .bus_cacheable(bus_cacheable),
        .store_done(store_done), .store_fail(store_fail),
        .monitor_set(monitor_set));
    // second copy in a system without a global monitor
    exmon_top #(.HAS_GLOBAL(1'b0)) exmon_top_i2 (.core_clk(core_clk),
        .resetn(resetn), .req_valid(req_valid), .req_src(req_src),
        .req_tgt(req_tgt), .req_mem(req_mem), .req_shareable(req_shareable),
        .req_cacheable(req_cacheable), .exclusive_load_op(exclusive_load_op),
        .exclusive_store_op(exclusive_store_op), .exc_entry(exc_entry),
        .exc_return(exc_return), .bus_resp_valid(rv), .bus_resp_exokay(rx),
        .bus_excl(excl2), .bus_cacheable(), .store_done(), .store_fail(),
        .monitor_set(mon2));
    // third copy in a system without a protection unit
    exmon_top #(.HAS_PROT(1'b0)) exmon_top_i3 (.core_clk(core_clk),
        .resetn(resetn), .req_valid(req_valid), .req_src(req_src),
        .req_tgt(req_tgt), .req_mem(req_mem), .req_shareable(req_shareable),
        .req_cacheable(req_cacheable), .exclusive_load_op(exclusive_load_op),
        .exclusive_store_op(exclusive_store_op), .exc_entry(exc_entry),
        .exc_return(exc_return), .bus_resp_valid(rv), .bus_resp_exokay(rx),
        .bus_excl(excl3), .bus_cacheable(), .store_done(), .store_fail(),
        .monitor_set());
    task automatic check(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t saw %b want %b", $time, seen, exp);
        end
    endtask
    // one access held for a single taking edge
    task automatic acc(input exmon_src_t s, input exmon_tgt_t t,
        input exmon_mem_t m, input logic sh, input logic ld);
        @(posedge core_clk) #1;
        req_valid = 1'b1;
        req_src = s;
        req_tgt = t;
        req_mem = m;
        req_shareable = sh;
        exclusive_load_op = ld;
        exclusive_store_op = !ld;
        @(posedge core_clk) #1;
        req_valid = 1'b0;
        exclusive_load_op = 1'b0;
        exclusive_store_op = 1'b0;
    endtask
    // external answers arrive late, so poll under a bound
    task automatic wait_done(input logic fail_exp);
        int n;
        n = 0;
        while (store_done !== 1'b1 && n < 20) begin
            @(posedge core_clk) #1;
            n++;
        end
        check(store_done, 1'b1);
        check(store_fail, fail_exp);
        check(monitor_set, 1'b0);
    endtask
    task automatic t_local;
        exmon_tgt_t t;
        for (int i = 0; i < 3; i++) begin
            t = exmon_tgt_t'(i);
            acc(EXMON_SRC_CORE, t, EXMON_MEM_NORMAL, 1'b0, 1'b1);
            check(monitor_set, 1'b1);
            check(bus_excl, 1'b0);
            // store far from the load address still pairs with it
            acc(EXMON_SRC_CORE, EXMON_TGT_PRIV, EXMON_MEM_NORMAL, 1'b0, 1'b0);
            wait_done(1'b0);
        end
    endtask
    task automatic t_ignored;
        acc(EXMON_SRC_CORE, EXMON_TGT_PRIV, EXMON_MEM_NORMAL, 1'b0, 1'b1);
        check(monitor_set, 1'b0);
        for (int i = 1; i < 4; i++) begin
            acc(exmon_src_t'(i), EXMON_TGT_TCM, EXMON_MEM_NORMAL, 1'b0, 1'b1);
            check(monitor_set, 1'b0);
        end
        acc(EXMON_SRC_CORE, EXMON_TGT_TCM, EXMON_MEM_NORMAL, 1'b0, 1'b0);
        wait_done(1'b1);
    endtask
    task automatic t_exc;
        acc(EXMON_SRC_CORE, EXMON_TGT_TCM, EXMON_MEM_NORMAL, 1'b0, 1'b1);
        check(monitor_set, 1'b1);
        exc_entry = 1'b1;
        @(posedge core_clk) #1;
        exc_entry = 1'b0;
        check(monitor_set, 1'b0);
        acc(EXMON_SRC_CORE, EXMON_TGT_TCM, EXMON_MEM_NORMAL, 1'b0, 1'b1);
        exc_return = 1'b1;
        @(posedge core_clk) #1;
        exc_return = 1'b0;
        check(monitor_set, 1'b0);
    endtask
    task automatic t_ext;
        acc(EXMON_SRC_CORE, EXMON_TGT_MAIN, EXMON_MEM_DEVICE, 1'b0, 1'b1);
        check(bus_excl, 1'b1);
        check(excl3, 1'b1);
        acc(EXMON_SRC_CORE, EXMON_TGT_MAIN, EXMON_MEM_DEVICE, 1'b0, 1'b0);
        wait_done(1'b0);
        give_okay = 1'b0;
        req_cacheable = 1'b1;
        acc(EXMON_SRC_CORE, EXMON_TGT_PERIPH, EXMON_MEM_NORMAL, 1'b1, 1'b1);
        check(bus_excl, 1'b1);
        check(bus_cacheable, 1'b0);
        check(mon2, 1'b0);
        check(excl2, 1'b1);
        check(excl3, 1'b0);
        acc(EXMON_SRC_CORE, EXMON_TGT_PERIPH, EXMON_MEM_NORMAL, 1'b1, 1'b0);
        wait_done(1'b1);
        give_okay = 1'b1;
        req_cacheable = 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // generous span: the sequence needs only a few dozen cycles
    initial begin
        #40000;
        fails++;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(posedge core_clk);
        #1 resetn = 1'b1;
        check(monitor_set, EXMON_RESET_OPEN);
        check(store_done, 1'b0);
        t_local;
        t_ignored;
        t_exc;
        t_ext;
        tally_and_finish;
    end
endmodule
